// *** rtl/asrc_regs.sv ***
// status and remote-control register bank with discrete line merging
`timescale 1ns/1ps
`default_nettype none
module asrc_regs #(
	parameter int FAULT_WORDS = asrc_pkg::FAULT_WORDS
) (
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	input  wire logic                      req_valid_i,
	input  wire asrc_pkg::asrc_req_t       req_i,
	output logic                           ack_o,
	output logic                           err_o,
	output logic [15:0]                    rdata_o,
	input  wire logic [3:0]                alarm_flags_i,
	input  wire logic [3:0]                op_mode_i,
	input  wire logic [FAULT_WORDS*16-1:0] fault_codes_i,
	input  wire logic                      cycle_sync_i,
	input  wire logic                      maint_switch_i,
	input  wire logic                      standby_line_i,
	input  wire logic                      standby_fitted_i,
	input  wire logic [1:0]                range_lines_i,
	input  wire logic                      range_fitted_i,
	output logic [1:0]                     range_lines_o,
	output logic                           range_lines_oe_o,
	input  wire logic [5:0]                stream_lines_i,
	output logic                           standby_req_o,
	output logic [1:0]                     range_sel_o,
	output logic [5:0]                     stream_sel_o,
	output logic                           cmd_valid_o,
	output asrc_pkg::asrc_cmd_t            cmd_code_o
);
	asrc_pkg::asrc_pins_t pins_raw;
	asrc_pkg::asrc_pins_t pins_s;

	logic [2:0]  cmd_q;
	logic        stby_q;
	logic [1:0]  range_q;
	logic [5:0]  stream_q;
	logic        dbg_q;
	logic        cmd_valid_q;
	asrc_pkg::asrc_cmd_t cmd_code_q;
	logic        ack_q;
	logic        err_q;
	logic [15:0] rdata_q;
	logic [15:0] rd_d;
	logic        hit_d;
	logic [4:0]  fidx;
	logic [15:0] fault_word;
	logic        wr;
	logic        rd;
	logic [15:0] op_word;

	assign wr = req_valid_i && req_i.we;
	assign rd = req_valid_i && !req_i.we;

	// fault word index; the slot before the last address is a gap
	function automatic logic [4:0] fault_slot(input logic [19:0] a);
		logic [19:0] off;
		off = a - asrc_pkg::ADDR_FAULT_FIRST;
		if (a == asrc_pkg::ADDR_FAULT_LAST)
			fault_slot = {1'b1, asrc_pkg::FAULT_LAST_IX};
		else if (a >= asrc_pkg::ADDR_FAULT_FIRST && off < 20'(FAULT_WORDS - 1))
			fault_slot = {1'b1, off[3:0]};
		else
			fault_slot = 5'h00;
	endfunction : fault_slot

	function automatic logic in_range(input logic [15:0] v, input logic [15:0] lim);
		in_range = (v <= lim);
	endfunction : in_range

	assign pins_raw = '{standby: standby_line_i, standby_fit: standby_fitted_i,
		maint: maint_switch_i, range: range_lines_i, range_fit: range_fitted_i,
		stream: stream_lines_i};

	asrc_sync #(
		.W ($bits(asrc_pkg::asrc_pins_t))
	) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (pins_raw),
		.q_o   (pins_s)
	);

	assign fidx = fault_slot(req_i.addr);

	asrc_fault_mux #(
		.WORDS (FAULT_WORDS)
	) u_fault (
		.codes_i (fault_codes_i),
		.idx_i   (fidx[3:0]),
		.word_o  (fault_word)
	);

	// effective selections merged with discrete lines
	assign standby_req_o = stby_q | (pins_s.standby_fit & pins_s.standby);
	assign stream_sel_o  = stream_q | pins_s.stream;
	assign range_sel_o   = (range_q == 2'h0 && pins_s.range_fit) ? pins_s.range : range_q;
	assign range_lines_oe_o = !pins_s.range_fit;
	assign range_lines_o    = range_q;

	assign op_word = {10'h000, pins_s.maint, standby_req_o, op_mode_i};

	// writable registers; out-of-range values leave the old contents
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stby_q <= asrc_pkg::RESET_STANDBY;
		end else if (wr && req_i.addr == asrc_pkg::ADDR_STANDBY
				&& in_range(req_i.wdata, asrc_pkg::MAX_STANDBY)) begin
			stby_q <= req_i.wdata[0];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			range_q <= asrc_pkg::RESET_RANGE;
		end else if (wr && req_i.addr == asrc_pkg::ADDR_RANGE
				&& in_range(req_i.wdata, asrc_pkg::MAX_RANGE)) begin
			range_q <= req_i.wdata[1:0];
		end
	end

	// bit 6 is accepted by the range check but has no stream behind it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stream_q <= asrc_pkg::RESET_STREAM;
		end else if (wr && req_i.addr == asrc_pkg::ADDR_STREAM
				&& in_range(req_i.wdata, asrc_pkg::MAX_STREAM)) begin
			stream_q <= req_i.wdata[5:0];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			dbg_q <= asrc_pkg::RESET_DEBUG;
		end else if (wr && req_i.addr == asrc_pkg::ADDR_DEBUG
				&& in_range(req_i.wdata, asrc_pkg::MAX_DEBUG)) begin
			dbg_q <= req_i.wdata[0];
		end
	end

	// command: one pulse per accepted nonzero write, held value reads back
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cmd_q       <= asrc_pkg::RESET_COMMAND;
			cmd_valid_q <= 1'b0;
			cmd_code_q  <= asrc_pkg::ASRC_CMD_NONE;
		end else begin
			cmd_valid_q <= 1'b0;
			if (wr && req_i.addr == asrc_pkg::ADDR_COMMAND
					&& in_range(req_i.wdata, asrc_pkg::MAX_COMMAND)) begin
				cmd_q <= req_i.wdata[2:0];
				if (req_i.wdata[2:0] != 3'h0) begin
					cmd_valid_q <= 1'b1;
					cmd_code_q  <= asrc_pkg::asrc_cmd_t'(req_i.wdata[2:0]);
				end
			end
		end
	end

	assign cmd_valid_o = cmd_valid_q;
	assign cmd_code_o  = cmd_code_q;

	// read decode; read-only registers swallow writes without effect
	always_comb begin
		rd_d  = 16'h0000;
		hit_d = 1'b1;
		if (fidx[4]) begin
			rd_d = dbg_q ? asrc_pkg::CANNED_FAULT : fault_word;
		end else begin
			case (req_i.addr)
				asrc_pkg::ADDR_ALARM:    rd_d = dbg_q ? asrc_pkg::CANNED_ALARM : {12'h000, alarm_flags_i};
				asrc_pkg::ADDR_OP_STATE: rd_d = dbg_q ? asrc_pkg::CANNED_OP : op_word;
				asrc_pkg::ADDR_MARKER:   rd_d = dbg_q ? asrc_pkg::CANNED_MARKER : {15'h0000, cycle_sync_i};
				asrc_pkg::ADDR_STANDBY:  rd_d = {15'h0000, stby_q};
				asrc_pkg::ADDR_RANGE:    rd_d = {14'h0000, range_q};
				asrc_pkg::ADDR_STREAM:   rd_d = {10'h000, stream_q};
				asrc_pkg::ADDR_DEBUG:    rd_d = {15'h0000, dbg_q};
				asrc_pkg::ADDR_COMMAND:  rd_d = {13'h0000, cmd_q};
				default:                 hit_d = 1'b0;
			endcase
		end
	end

	// every request is answered on the next edge, ack or err
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ack_q   <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			ack_q <= req_valid_i && hit_d;
			err_q <= req_valid_i && !hit_d;
			if (rd && hit_d)
				rdata_q <= rd_d;
		end
	end

	assign ack_o   = ack_q;
	assign err_o   = err_q;
	assign rdata_o = rdata_q;

	sequence s_cmd_write;
		wr && req_i.addr == asrc_pkg::ADDR_COMMAND;
	endsequence

	sequence s_cmd_good;
		s_cmd_write ##0 (req_i.wdata <= asrc_pkg::MAX_COMMAND) && (req_i.wdata != 16'h0000);
	endsequence

	sequence s_read_at(logic [19:0] a);
		rd && req_i.addr == a;
	endsequence

	a_cmd_pulse_once: assert property (@(posedge clk_i) disable iff (rst_i)
		s_cmd_good |=> cmd_valid_o && cmd_code_o == $past(req_i.wdata[2:0]) ##1 (!cmd_valid_o || $past(wr)))
		else $error("command pulse wrong");

	a_cmd_bad_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
		s_cmd_write ##0 (req_i.wdata > asrc_pkg::MAX_COMMAND) |=> !cmd_valid_o && $stable(cmd_q))
		else $error("out-of-range command acted on");

	a_standby_set: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && req_i.addr == asrc_pkg::ADDR_STANDBY && req_i.wdata == 16'h0001 |=> standby_req_o)
		else $error("standby request not raised");

	a_range_write: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && req_i.addr == asrc_pkg::ADDR_RANGE && req_i.wdata != 16'h0000
		&& req_i.wdata <= asrc_pkg::MAX_RANGE |=> range_sel_o == $past(req_i.wdata[1:0]))
		else $error("range selection not taken from register");

	a_range_drive: assert property (@(posedge clk_i) disable iff (rst_i)
		!pins_s.range_fit |-> range_lines_oe_o && range_lines_o == range_sel_o)
		else $error("range lines not driven from register");

	a_stream_merge: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && req_i.addr == asrc_pkg::ADDR_STREAM && req_i.wdata <= asrc_pkg::MAX_STREAM
		|=> (stream_sel_o & $past(req_i.wdata[5:0])) == $past(req_i.wdata[5:0]))
		else $error("stream request lost");

	a_fault_first: assert property (@(posedge clk_i) disable iff (rst_i)
		rd && req_i.addr == asrc_pkg::ADDR_FAULT_FIRST && !dbg_q |=> ack_o && rdata_o == $past(fault_codes_i[15:0]))
		else $error("first fault word wrong");

	a_op_standby: assert property (@(posedge clk_i) disable iff (rst_i)
		rd && req_i.addr == asrc_pkg::ADDR_OP_STATE && !dbg_q |=> rdata_o[4] == $past(standby_req_o))
		else $error("standby bit in op state wrong");

	a_marker_mirror: assert property (@(posedge clk_i) disable iff (rst_i)
		rd && req_i.addr == asrc_pkg::ADDR_MARKER && !dbg_q |=> rdata_o == {15'h0000, $past(cycle_sync_i)})
		else $error("cycle marker does not mirror sync");

	a_debug_canned: assert property (@(posedge clk_i) disable iff (rst_i)
		rd && req_i.addr == asrc_pkg::ADDR_ALARM && dbg_q |=> rdata_o == asrc_pkg::CANNED_ALARM)
		else $error("debug mode did not return canned alarm");

	a_answer_once: assert property (@(posedge clk_i) disable iff (rst_i)
		req_valid_i |=> (ack_o ^ err_o))
		else $error("request not answered exactly once");

	a_alarm_live: assert property (@(posedge clk_i) disable iff (rst_i)
		s_read_at(asrc_pkg::ADDR_ALARM) ##0 !dbg_q |=> ack_o && rdata_o == {12'h000, $past(alarm_flags_i)})
		else $error("alarm summary word wrong");

	a_fault_last: assert property (@(posedge clk_i) disable iff (rst_i)
		s_read_at(asrc_pkg::ADDR_FAULT_LAST) ##0 !dbg_q
		|=> ack_o && rdata_o == $past(fault_codes_i[FAULT_WORDS*16-1 -: 16]))
		else $error("last fault word wrong");

	a_op_mode_bits: assert property (@(posedge clk_i) disable iff (rst_i)
		s_read_at(asrc_pkg::ADDR_OP_STATE) ##0 !dbg_q
		|=> rdata_o[3:0] == $past(op_mode_i) && rdata_o[15:6] == 10'h000)
		else $error("op state mode bits wrong");

	a_op_maint: assert property (@(posedge clk_i) disable iff (rst_i)
		s_read_at(asrc_pkg::ADDR_OP_STATE) ##0 !dbg_q |=> rdata_o[5] == $past(pins_s.maint))
		else $error("maintenance bit in op state wrong");

	a_cmd_zero_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
		s_cmd_write ##0 req_i.wdata == 16'h0000 |=> !cmd_valid_o && cmd_q == 3'h0)
		else $error("zero command acted on");

	a_cmd_purge_code: assert property (@(posedge clk_i) disable iff (rst_i)
		s_cmd_write ##0 req_i.wdata == 16'h0007 |=> cmd_valid_o && cmd_code_o == asrc_pkg::ASRC_CMD_PURGE_ZERO)
		else $error("purge command not decoded");

	a_standby_line: assert property (@(posedge clk_i) disable iff (rst_i)
		pins_s.standby_fit && pins_s.standby |-> standby_req_o)
		else $error("fitted standby line ignored");

	a_standby_unfit: assert property (@(posedge clk_i) disable iff (rst_i)
		!pins_s.standby_fit && !stby_q |-> !standby_req_o)
		else $error("standby raised without a source");

	a_standby_bad: assert property (@(posedge clk_i) disable iff (rst_i)
		wr && req_i.addr == asrc_pkg::ADDR_STANDBY && req_i.wdata > asrc_pkg::MAX_STANDBY |=> $stable(stby_q))
		else $error("invalid standby value taken");

	a_range_lines: assert property (@(posedge clk_i) disable iff (rst_i)
		range_q == 2'h0 && pins_s.range_fit |-> range_sel_o == pins_s.range)
		else $error("range not taken from fitted lines");

	a_stream_read: assert property (@(posedge clk_i) disable iff (rst_i)
		s_read_at(asrc_pkg::ADDR_STREAM) |=> ack_o && rdata_o == {10'h000, $past(stream_q)})
		else $error("stream register read back wrong");

	a_stream_lines: assert property (@(posedge clk_i) disable iff (rst_i)
		pins_s.stream != 6'h00 |-> (stream_sel_o & pins_s.stream) == pins_s.stream)
		else $error("stream line request lost");

	a_debug_fault: assert property (@(posedge clk_i) disable iff (rst_i)
		rd && fidx[4] && dbg_q |=> rdata_o == asrc_pkg::CANNED_FAULT)
		else $error("debug mode did not return canned fault word");

endmodule : asrc_regs
`default_nettype wire

// *** rtl/asrc_pkg.sv ***
// package: register map, canned debug values and request carrier for the status and remote-control bank
`default_nettype none
package asrc_pkg;

	localparam int          ADDR_W = 20;
	localparam int          DATA_W = 16;

	localparam logic [19:0] ADDR_DEBUG       = 20'h0afc8;
	localparam logic [19:0] ADDR_ALARM       = 20'h0c30a;
	localparam logic [19:0] ADDR_OP_STATE    = 20'h0c30b;
	localparam logic [19:0] ADDR_STANDBY     = 20'h0c30d;
	localparam logic [19:0] ADDR_MARKER      = 20'h0c30e;
	localparam logic [19:0] ADDR_RANGE       = 20'h0c30f;
	localparam logic [19:0] ADDR_STREAM      = 20'h0c310;
	localparam logic [19:0] ADDR_FAULT_FIRST = 20'h0c31e;
	localparam logic [19:0] ADDR_FAULT_LAST  = 20'h0c32e;
	localparam logic [19:0] ADDR_COMMAND     = 20'h79e84;

	localparam int          FAULT_WORDS   = 16;
	localparam logic [3:0]  FAULT_LAST_IX = 4'hf;

	localparam logic [15:0] MAX_COMMAND = 16'h0007;
	localparam logic [15:0] MAX_STANDBY = 16'h0001;
	localparam logic [15:0] MAX_RANGE   = 16'h0003;
	localparam logic [15:0] MAX_STREAM  = 16'h007f;
	localparam logic [15:0] MAX_DEBUG   = 16'h0001;

	localparam logic [2:0]  RESET_COMMAND = 3'h0;
	localparam logic        RESET_STANDBY = 1'b0;
	localparam logic [1:0]  RESET_RANGE   = 2'h0;
	localparam logic [5:0]  RESET_STREAM  = 6'h00;
	localparam logic        RESET_DEBUG   = 1'b0;

	// canned contents are arbitrary but fixed patterns for host-side testing
	localparam logic [15:0] CANNED_ALARM  = 16'h0005;
	localparam logic [15:0] CANNED_OP     = 16'h0011;
	localparam logic [15:0] CANNED_MARKER = 16'h0001;
	localparam logic [15:0] CANNED_FAULT  = 16'h8001;

	typedef enum logic [2:0] {
		ASRC_CMD_NONE,
		ASRC_CMD_STOP,
		ASRC_CMD_ANALYSIS,
		ASRC_CMD_ZERO_CAL,
		ASRC_CMD_ZERO_CHECK,
		ASRC_CMD_SPAN_CAL,
		ASRC_CMD_SPAN_CHECK,
		ASRC_CMD_PURGE_ZERO
	} asrc_cmd_t;

	typedef struct packed {
		logic              we;
		logic [19:0]       addr;
		logic [15:0]       wdata;
	} asrc_req_t;

	typedef struct packed {
		logic              standby;
		logic              standby_fit;
		logic              maint;
		logic [1:0]        range;
		logic              range_fit;
		logic [5:0]        stream;
	} asrc_pins_t;

endpackage : asrc_pkg
`default_nettype wire

// *** rtl/asrc_sync.sv ***
// two-flop synchroniser for a bundle of discrete input lines
`timescale 1ns/1ps
`default_nettype none
module asrc_sync #(
	parameter int W = 12
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// first stage read only by the second
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= d_i;
			sync_q <= meta_q;
		end
	end

	assign q_o = sync_q;
endmodule : asrc_sync
`default_nettype wire

// *** rtl/asrc_fault_mux.sv ***
// selects one sixteen-code word out of the fault code vector
`timescale 1ns/1ps
`default_nettype none
module asrc_fault_mux #(
	parameter int WORDS = 16
) (
	input  wire logic [WORDS*16-1:0] codes_i,
	input  wire logic [3:0]          idx_i,
	output logic      [15:0]         word_o
);
	// code n sits at vector bit n-1, so word k holds codes 16k+1 .. 16k+16
	always_comb begin
		word_o = codes_i[idx_i*16 +: 16];
	end
endmodule : asrc_fault_mux
`default_nettype wire

// *** test/asrc_master.sv ***
// partner model: register-access master issuing single-word requests
`timescale 1ns/1ps
`default_nettype none
module asrc_master (
	input  wire logic           clk_i,
	output logic                req_valid_o,
	output asrc_pkg::asrc_req_t req_o,
	input  wire logic           ack_i,
	input  wire logic           err_i,
	input  wire logic [15:0]    rdata_i
);
	initial begin
		req_valid_o = 1'b0;
		req_o = '0;
	end

	// strobe held through exactly one taking edge, answer read one cycle later
	task automatic xfer(input logic we, input logic [19:0] addr, input logic [15:0] wdata,
			output logic ack, output logic err, output logic [15:0] rdata);
		int n;
		n = 0;
		@(negedge clk_i);
		req_o = '{we: we, addr: addr, wdata: wdata};
		req_valid_o = 1'b1;
		@(negedge clk_i);
		req_valid_o = 1'b0;
		// released lines change pattern so a stale word is never mistaken for a request
		req_o = asrc_pkg::asrc_req_t'(~req_o);
		while (!(ack_i | err_i) && n < 4) begin
			@(negedge clk_i);
			n++;
		end
		ack = ack_i;
		err = err_i;
		rdata = rdata_i;
	endtask : xfer
endmodule : asrc_master
`default_nettype wire

// *** test/tb_top.sv ***
// testbench: register bank driven through the access port with discrete lines
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                clk_i, rst_i, req_valid_i, ack_o, err_o;
	asrc_pkg::asrc_req_t req_i;
	logic [15:0]         rdata_o;
	logic [3:0]          alarm_flags_i, op_mode_i;
	logic [255:0]        fault_codes_i;
	logic                cycle_sync_i, maint_switch_i, standby_line_i, standby_fitted_i, range_fitted_i;
	logic [1:0]          range_lines_i, range_lines_o, range_sel_o;
	logic                range_lines_oe_o, standby_req_o, cmd_valid_o;
	logic [5:0]          stream_lines_i, stream_sel_o;
	asrc_pkg::asrc_cmd_t cmd_code_o;
	logic                ack, err;
	logic [15:0]         rd;
	int                  err_total = 0;
	int                  cmp_count = 0;

	asrc_regs asrc_regs_i (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_i(req_i),
		.ack_o(ack_o), .err_o(err_o), .rdata_o(rdata_o), .alarm_flags_i(alarm_flags_i),
		.op_mode_i(op_mode_i), .fault_codes_i(fault_codes_i), .cycle_sync_i(cycle_sync_i),
		.maint_switch_i(maint_switch_i), .standby_line_i(standby_line_i),
		.standby_fitted_i(standby_fitted_i), .range_lines_i(range_lines_i),
		.range_fitted_i(range_fitted_i), .range_lines_o(range_lines_o),
		.range_lines_oe_o(range_lines_oe_o), .stream_lines_i(stream_lines_i),
		.standby_req_o(standby_req_o), .range_sel_o(range_sel_o), .stream_sel_o(stream_sel_o),
		.cmd_valid_o(cmd_valid_o), .cmd_code_o(cmd_code_o));

	asrc_master asrc_master_i (.clk_i(clk_i), .req_valid_o(req_valid_i), .req_o(req_i),
		.ack_i(ack_o), .err_i(err_o), .rdata_i(rdata_o));

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic wr(input logic [19:0] a, input logic [15:0] d);
		asrc_master_i.xfer(1'b1, a, d, ack, err, rd);
		chk({14'h0, err, ack}, 16'h0001);
	endtask : wr

	task automatic rdc(input logic [19:0] a, input logic [15:0] e);
		asrc_master_i.xfer(1'b0, a, 16'h0000, ack, err, rd);
		chk({14'h0, err, ack}, 16'h0001);
		chk(rd, e);
	endtask : rdc

	// pins pass a two-flop synchroniser, so allow three edges
	task automatic settle;
		repeat (3) @(negedge clk_i);
	endtask : settle

	function automatic logic [15:0] fword(input int k);
		return {4'(k), 12'h3c0} ^ 16'(k);
	endfunction : fword

	initial begin
		#100us;
		err_total++;
		final_report();
	end

	initial begin
		rst_i = 1'b1;
		alarm_flags_i = 4'h0;
		op_mode_i = 4'h0;
		fault_codes_i = '0;
		{cycle_sync_i, maint_switch_i, standby_line_i, standby_fitted_i, range_fitted_i} = 5'h00;
		range_lines_i = 2'h0;
		stream_lines_i = 6'h00;
		repeat (12) @(posedge clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		chk({15'h0, range_lines_oe_o}, 16'h0001);
		rdc(asrc_pkg::ADDR_STANDBY, 16'h0000);
		rdc(asrc_pkg::ADDR_RANGE, 16'h0000);
		rdc(asrc_pkg::ADDR_STREAM, 16'h0000);
		rdc(asrc_pkg::ADDR_DEBUG, 16'h0000);
		$display("test reset done");
		alarm_flags_i = 4'ha;
		rdc(asrc_pkg::ADDR_ALARM, 16'h000a);
		wr(asrc_pkg::ADDR_ALARM, 16'hffff);
		rdc(asrc_pkg::ADDR_ALARM, 16'h000a);
		for (int k = 0; k < 16; k++) fault_codes_i[k*16 +: 16] = fword(k);
		for (int k = 0; k < 16; k++) begin
			rdc((k == 15) ? asrc_pkg::ADDR_FAULT_LAST : asrc_pkg::ADDR_FAULT_FIRST + 20'(k), fword(k));
		end
		asrc_master_i.xfer(1'b0, 20'h0c32d, 16'h0000, ack, err, rd);
		chk({14'h0, err, ack}, 16'h0002);
		$display("test status words done");
		wr(asrc_pkg::ADDR_DEBUG, 16'h0001);
		rdc(asrc_pkg::ADDR_ALARM, asrc_pkg::CANNED_ALARM);
		rdc(asrc_pkg::ADDR_FAULT_LAST, asrc_pkg::CANNED_FAULT);
		rdc(asrc_pkg::ADDR_MARKER, asrc_pkg::CANNED_MARKER);
		rdc(asrc_pkg::ADDR_OP_STATE, asrc_pkg::CANNED_OP);
		wr(asrc_pkg::ADDR_DEBUG, 16'h0002);
		rdc(asrc_pkg::ADDR_DEBUG, 16'h0001);
		wr(asrc_pkg::ADDR_DEBUG, 16'h0000);
		rdc(asrc_pkg::ADDR_ALARM, 16'h000a);
		$display("test debug done");
		op_mode_i = 4'h5;
		maint_switch_i = 1'b1;
		wr(asrc_pkg::ADDR_STANDBY, 16'h0001);
		settle();
		rdc(asrc_pkg::ADDR_OP_STATE, 16'h0035);
		chk({15'h0, standby_req_o}, 16'h0001);
		wr(asrc_pkg::ADDR_STANDBY, 16'h0002);
		rdc(asrc_pkg::ADDR_STANDBY, 16'h0001);
		wr(asrc_pkg::ADDR_STANDBY, 16'h0000);
		standby_line_i = 1'b1;
		settle();
		chk({15'h0, standby_req_o}, 16'h0000);
		standby_fitted_i = 1'b1;
		settle();
		chk({15'h0, standby_req_o}, 16'h0001);
		rdc(asrc_pkg::ADDR_OP_STATE, 16'h0035);
		standby_line_i = 1'b0;
		maint_switch_i = 1'b0;
		settle();
		rdc(asrc_pkg::ADDR_OP_STATE, 16'h0005);
		$display("test standby done");
		for (int c = 0; c < 8; c++) begin
			wr(asrc_pkg::ADDR_COMMAND, 16'(c));
			chk({15'h0, cmd_valid_o}, 16'(c != 0));
			if (c != 0) chk({13'h0, cmd_code_o}, 16'(c));
			@(negedge clk_i);
			chk({15'h0, cmd_valid_o}, 16'h0000);
			rdc(asrc_pkg::ADDR_COMMAND, 16'(c));
		end
		wr(asrc_pkg::ADDR_COMMAND, 16'h0008);
		chk({15'h0, cmd_valid_o}, 16'h0000);
		rdc(asrc_pkg::ADDR_COMMAND, 16'h0007);
		$display("test command done");
		cycle_sync_i = 1'b1;
		rdc(asrc_pkg::ADDR_MARKER, 16'h0001);
		cycle_sync_i = 1'b0;
		rdc(asrc_pkg::ADDR_MARKER, 16'h0000);
		wr(asrc_pkg::ADDR_RANGE, 16'h0002);
		settle();
		chk({12'h0, range_sel_o, range_lines_o}, 16'h000a);
		chk({15'h0, range_lines_oe_o}, 16'h0001);
		wr(asrc_pkg::ADDR_RANGE, 16'h0004);
		rdc(asrc_pkg::ADDR_RANGE, 16'h0002);
		range_fitted_i = 1'b1;
		range_lines_i = 2'h3;
		settle();
		chk({15'h0, range_lines_oe_o}, 16'h0000);
		chk({14'h0, range_sel_o}, 16'h0002);
		wr(asrc_pkg::ADDR_RANGE, 16'h0000);
		settle();
		chk({14'h0, range_sel_o}, 16'h0003);
		range_fitted_i = 1'b0;
		settle();
		chk({14'h0, range_sel_o}, 16'h0000);
		$display("test marker and range done");
		stream_lines_i = 6'h20;
		wr(asrc_pkg::ADDR_STREAM, 16'h0005);
		settle();
		chk({10'h0, stream_sel_o}, 16'h0025);
		rdc(asrc_pkg::ADDR_STREAM, 16'h0005);
		wr(asrc_pkg::ADDR_STREAM, 16'h0080);
		rdc(asrc_pkg::ADDR_STREAM, 16'h0005);
		wr(asrc_pkg::ADDR_STREAM, 16'h007f);
		rdc(asrc_pkg::ADDR_STREAM, 16'h003f);
		$display("test stream done");
		final_report();
	end
endmodule : tb_top
`default_nettype wire
